// *** rsv_host_model.sv ***
// Host side: pull-up on the open-drain pin and a count of reset entries
`timescale 1ns/10ps
module rsv_host_model (
	input  wire logic systemReset_n,
	input  wire logic pinOe,
	input  wire logic pinOut,
	output logic      pinLevel,
	output int        resetEntries
);
	// Released pin floats to the pull-up, never the last driven level
	assign pinLevel = pinOe ? pinOut : 1'b1;
	initial resetEntries = 0;
	always @(negedge systemReset_n) resetEntries++;
endmodule

// *** rsv_low_filter.sv ***
// Low-pulse glitch filter for an external reset input
`timescale 1ns/10ps
module rsv_low_filter #(
	parameter int COUNT_W       = 4,
	parameter int REJECT_CYCLES = 7
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic pinIn,
	output logic      lowValid
);
	logic [COUNT_W-1:0] lowCount;

	// Count consecutive low cycles; a high restarts the count
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lowCount <= '0;
			lowValid <= 1'b0;
		end else if (pinIn) begin
			lowCount <= '0;
			lowValid <= 1'b0;
		end else if (lowCount == COUNT_W'(REJECT_CYCLES - 1)) begin
			lowValid <= 1'b1;
		end else begin
			lowCount <= lowCount + COUNT_W'(1);
		end
	end
endmodule

// *** rsv_pkg.sv ***
// Constants shared by the real-time clock supervisor block
package rsv_pkg;
	// Clock rate
	localparam longint CLK_FREQ_HZ = 125_000_000;

	// Register indexes; byte address is four times the index
	localparam int IDX_SECONDS   = 'h01;
	localparam int IDX_CENTURY   = 'h03;
	localparam int IDX_DESELECT  = 'h04;
	localparam int IDX_CONTROL   = 'h08;
	localparam int IDX_WATCHDOG  = 'h09;
	localparam int IDX_ALARM_MON = 'h0a;
	localparam int IDX_FLAGS     = 'h0f;
	localparam logic [7:0] ADDR_SECONDS   = 8'(IDX_SECONDS * 4);
	localparam logic [7:0] ADDR_CENTURY   = 8'(IDX_CENTURY * 4);
	localparam logic [7:0] ADDR_DESELECT  = 8'(IDX_DESELECT * 4);
	localparam logic [7:0] ADDR_CONTROL   = 8'(IDX_CONTROL * 4);
	localparam logic [7:0] ADDR_WATCHDOG  = 8'(IDX_WATCHDOG * 4);
	localparam logic [7:0] ADDR_ALARM_MON = 8'(IDX_ALARM_MON * 4);
	localparam logic [7:0] ADDR_FLAGS     = 8'(IDX_FLAGS * 4);

	// Field positions
	localparam int BIT_OSC_HALT        = 7;
	localparam int BIT_CENTURY_ENABLE  = 7;
	localparam int BIT_CENTURY_FLAG    = 6;
	localparam int BIT_DESELECT_SELECT = 7;
	localparam int BIT_PIN_LEVEL       = 7;
	localparam int BIT_FREQ_TEST       = 6;
	localparam int BIT_ALARM_FLAG_EN   = 7;
	localparam int BIT_SQUARE_WAVE_EN  = 6;
	localparam int BIT_ALARM_BACKUP_EN = 5;
	localparam int BIT_BATTERY_WEAK    = 4;

	// Values after initial power application
	localparam logic [7:0] RESET_SECONDS   = 8'h00;
	localparam logic [7:0] RESET_CENTURY   = 8'h00;
	localparam logic [7:0] RESET_DESELECT  = 8'h00;
	localparam logic [7:0] RESET_CONTROL   = 8'h80;
	localparam logic [7:0] RESET_WATCHDOG  = 8'h00;
	localparam logic [7:0] RESET_ALARM_MON = 8'h00;
	localparam logic       DEFAULT_DESELECT_SELECT = 1'b0;
	localparam logic       DEFAULT_OSC_HALT        = 1'b0;
	localparam logic       DEFAULT_PIN_LEVEL       = 1'b1;

	// Times as printed and their cycle counts
	localparam longint FAST_REJECT_NS    = 50;
	localparam longint SLOW_REJECT_MS    = 20;
	localparam longint HOLD_NORMAL_MS    = 96;
	localparam longint HOLD_HALTED_MS    = 40;
	localparam longint HOLD_SHORT_US     = 50;
	localparam longint RELEASE_LONG_MS   = 2;
	localparam longint BATTERY_PERIOD_H  = 24;
	localparam int FAST_REJECT_CYCLES =
		int'((FAST_REJECT_NS * CLK_FREQ_HZ + 64'd999_999_999) / 64'd1_000_000_000);
	localparam longint SLOW_REJECT_CYCLES = SLOW_REJECT_MS * CLK_FREQ_HZ / 1000;
	localparam longint HOLD_NORMAL_CYCLES = HOLD_NORMAL_MS * CLK_FREQ_HZ / 1000;
	localparam longint HOLD_HALTED_CYCLES = HOLD_HALTED_MS * CLK_FREQ_HZ / 1000;
	localparam longint HOLD_SHORT_CYCLES  = HOLD_SHORT_US * CLK_FREQ_HZ / 1_000_000;
	localparam longint RELEASE_LONG_CYCLES = RELEASE_LONG_MS * CLK_FREQ_HZ / 1000;
	localparam longint BATTERY_PERIOD_CYCLES = BATTERY_PERIOD_H * 3600 * CLK_FREQ_HZ;

	// Counter widths
	localparam int HOLD_W    = 24;
	localparam int FAST_W    = 4;
	localparam int SLOW_W    = 22;
	localparam int BATTERY_W = 44;

	typedef enum logic [1:0] {
		RSV_BACKUP,
		RSV_RECOVER,
		RSV_RUN,
		RSV_IN_RESET
	} rsv_power_e;
endpackage

// *** rsv_supervisor.sv ***
// Supervisor: reset sequencing, power-fail flag, defaults and supervisory registers
//
// Notes on behaviour
// - Two reset inputs each drive system reset
// - Fast input: reject lows under 50 ns
// - Slow input: reject lows under 20 ms
// - Release reset after selectable delay
// - Power-fail flag follows sense when enabled
// - Backup disables comparator, flag held low
// - On return force flag high for hold
// - Century flag toggles at rollover when enabled
// - Open-drain pin follows level bit when idle
// - Test battery at power-up and daily
// - Weak flag stays until a passing test
// - Battery tests only with supply present
// - Deselect extended after supply; writes rejected
// - Hold time chosen by select and halt
// - Initial power-up register defaults
// - Retained power-up keeps select, halt, level
// - Watchdog register fully cleared at power-up
// - Supply trip pulls system reset low
// - Halt bit one stops the oscillator
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
module rsv_supervisor #(
	parameter longint SLOW_REJECT   = rsv_pkg::SLOW_REJECT_CYCLES,
	parameter longint HOLD_NORMAL   = rsv_pkg::HOLD_NORMAL_CYCLES,
	parameter longint HOLD_HALTED   = rsv_pkg::HOLD_HALTED_CYCLES,
	parameter longint HOLD_SHORT    = rsv_pkg::HOLD_SHORT_CYCLES,
	parameter longint RELEASE_LONG  = rsv_pkg::RELEASE_LONG_CYCLES,
	parameter longint BATTERY_CHECK = rsv_pkg::BATTERY_PERIOD_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        resetInFast_n,
	input  wire logic        resetInSlow_n,
	input  wire logic        powerfailSenseBelow,
	input  wire logic        supplyValid,
	input  wire logic        batteryRetained,
	input  wire logic        batteryBelowLimit,
	input  wire logic        centuryRollover,
	output logic             systemReset_n,
	output logic             powerfailFlagOut,
	output logic             multiFunctionPinOut,
	output logic             multiFunctionPinOe,
	output logic             oscillatorRun
);
	import rsv_pkg::*;

	rsv_power_e          powerState;
	logic [HOLD_W-1:0]   holdCount;
	logic [BATTERY_W-1:0] batteryCount;
	logic [7:0]          secondsReg;
	logic [7:0]          centuryHoursClock;
	logic [7:0]          deselectSelectClock;
	logic [7:0]          controlReg;
	logic [7:0]          watchdogReg;
	logic [7:0]          alarmMonthReg;
	logic                batteryWeakFlag;
	logic                fastLow;
	logic                slowLow;
	logic                anyResetLow;
	logic                powerUp;
	logic                powerDown;
	logic                writesOpen;
	logic                accessDone;
	logic                writeDone;
	logic [7:0]          readValue;
	logic                mapped;
	logic                next_select;
	logic                next_halt;
	logic [HOLD_W-1:0]   next_holdLoad;
	logic [HOLD_W-1:0]   releaseLoad;

	// Filter the fast reset input
	// fast low filter
	rsv_low_filter #(
		.COUNT_W      (FAST_W),
		.REJECT_CYCLES(FAST_REJECT_CYCLES)
	) fastFilter (
		.clk     (clk),
		.reset   (reset),
		.pinIn   (resetInFast_n),
		.lowValid(fastLow)
	);

	rsv_low_filter #(
		.COUNT_W      (SLOW_W),
		.REJECT_CYCLES(int'(SLOW_REJECT))
	) slowFilter (
		.clk     (clk),
		.reset   (reset),
		.pinIn   (resetInSlow_n),
		.lowValid(slowLow)
	);

	assign anyResetLow = fastLow | slowLow;
	assign powerUp     = (powerState == RSV_BACKUP) & supplyValid;
	assign powerDown   = (powerState != RSV_BACKUP) & ~supplyValid;

	// Select and halt as they will stand once power-up defaults are applied
	// retained keeps select and halt
	always_comb begin
		next_select = batteryRetained ? deselectSelectClock[BIT_DESELECT_SELECT]
			: DEFAULT_DESELECT_SELECT;
		next_halt   = batteryRetained ? secondsReg[BIT_OSC_HALT] : DEFAULT_OSC_HALT;
	end

	always_comb begin
		if (next_select) begin
			next_holdLoad = HOLD_W'(HOLD_SHORT);
		end else if (next_halt) begin
			next_holdLoad = HOLD_W'(HOLD_HALTED);
		end else begin
			next_holdLoad = HOLD_W'(HOLD_NORMAL);
		end
	end

	// release delay selected by deselect bit
	always_comb begin
		if (deselectSelectClock[BIT_DESELECT_SELECT]) begin
			releaseLoad = HOLD_W'(HOLD_SHORT);
		end else begin
			releaseLoad = HOLD_W'(RELEASE_LONG);
		end
	end

	// Power and reset sequencing
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			powerState <= RSV_BACKUP;
			holdCount  <= '0;
		end else begin
			case (powerState)
				RSV_BACKUP: begin
					if (supplyValid) begin
						powerState <= RSV_RECOVER;
						holdCount  <= next_holdLoad;
					end
				end
				RSV_RECOVER: begin
					if (!supplyValid) begin
						powerState <= RSV_BACKUP;
					end else if (holdCount <= HOLD_W'(1)) begin
						powerState <= RSV_RUN;
					end else begin
						holdCount <= holdCount - HOLD_W'(1);
					end
				end
				RSV_RUN: begin
					// input reset reloads the release delay; no power-up defaults
					if (!supplyValid) begin
						powerState <= RSV_BACKUP;
					end else if (anyResetLow) begin
						powerState <= RSV_IN_RESET;
						holdCount  <= releaseLoad;
					end
				end
				RSV_IN_RESET: begin
					// restart delay while any input is low
					if (!supplyValid) begin
						powerState <= RSV_BACKUP;
					end else if (anyResetLow) begin
						holdCount <= releaseLoad;
					end else if (holdCount <= HOLD_W'(1)) begin
						powerState <= RSV_RUN;
					end else begin
						holdCount <= holdCount - HOLD_W'(1);
					end
				end
				default: begin
					powerState <= RSV_BACKUP;
				end
			endcase
		end
	end

	// System reset is low everywhere except normal running
	// reset output
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			systemReset_n <= 1'b0;
		end else begin
			systemReset_n <= (powerState == RSV_RUN) & supplyValid & ~anyResetLow;
		end
	end

	// Power-fail flag gating
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			powerfailFlagOut <= 1'b0;
		end else begin
			case (powerState)
				RSV_BACKUP: begin
					powerfailFlagOut <= supplyValid;
				end
				RSV_RECOVER: begin
					powerfailFlagOut <= supplyValid;
				end
				default: begin
					powerfailFlagOut <= supplyValid & ~powerfailSenseBelow;
				end
			endcase
		end
	end

	// APB slave: one wait state, then pready for one cycle
	assign accessDone = psel & penable & pready;
	assign writesOpen = (powerState == RSV_RUN) | (powerState == RSV_IN_RESET);
	assign writeDone  = accessDone & pwrite & mapped & writesOpen;

	always_comb begin
		mapped    = 1'b1;
		readValue = 8'h00;
		case (paddr)
			ADDR_SECONDS:   readValue = secondsReg;
			ADDR_CENTURY:   readValue = centuryHoursClock;
			ADDR_DESELECT:  readValue = deselectSelectClock;
			ADDR_CONTROL:   readValue = controlReg;
			ADDR_WATCHDOG:  readValue = watchdogReg;
			ADDR_ALARM_MON: readValue = alarmMonthReg;
			ADDR_FLAGS: begin
				readValue[BIT_BATTERY_WEAK] = batteryWeakFlag;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= ~mapped | (pwrite & ~writesOpen) | (pwrite & (paddr == ADDR_FLAGS));
			prdata  <= {24'h000000, readValue};
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Century and hours register; the hardware toggle beats a software write
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			centuryHoursClock <= RESET_CENTURY;
		end else begin
			if (writeDone && paddr == ADDR_CENTURY) begin
				centuryHoursClock <= pwdata[7:0];
			end
			if (centuryRollover && centuryHoursClock[BIT_CENTURY_ENABLE]) begin
				centuryHoursClock[BIT_CENTURY_FLAG] <= ~centuryHoursClock[BIT_CENTURY_FLAG];
			end
		end
	end

	// Deselect select register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			deselectSelectClock <= RESET_DESELECT;
		end else if (powerUp) begin
			deselectSelectClock[BIT_DESELECT_SELECT] <= next_select;
		end else if (writeDone && paddr == ADDR_DESELECT) begin
			deselectSelectClock <= pwdata[7:0];
		end
	end

	// Seconds register carrying the oscillator halt bit
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			secondsReg <= RESET_SECONDS;
		end else if (powerUp) begin
			secondsReg[BIT_OSC_HALT] <= next_halt;
		end else if (writeDone && paddr == ADDR_SECONDS) begin
			secondsReg <= pwdata[7:0];
		end
	end

	// Control register: pin level and frequency test
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			controlReg <= RESET_CONTROL;
		end else if (powerDown) begin
			controlReg[BIT_FREQ_TEST] <= 1'b0;
		end else if (powerUp) begin
			controlReg[BIT_FREQ_TEST] <= 1'b0;
			if (!batteryRetained) begin
				controlReg[BIT_PIN_LEVEL] <= DEFAULT_PIN_LEVEL;
			end
		end else if (writeDone && paddr == ADDR_CONTROL) begin
			controlReg <= pwdata[7:0];
		end
	end

	// Watchdog and alarm-enable registers cleared at every power-up
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			watchdogReg   <= RESET_WATCHDOG;
			alarmMonthReg <= RESET_ALARM_MON;
		end else if (powerUp) begin
			watchdogReg <= RESET_WATCHDOG;
			alarmMonthReg[BIT_ALARM_FLAG_EN]   <= 1'b0;
			alarmMonthReg[BIT_SQUARE_WAVE_EN]  <= 1'b0;
			alarmMonthReg[BIT_ALARM_BACKUP_EN] <= 1'b0;
		end else if (writeDone) begin
			if (paddr == ADDR_WATCHDOG) begin
				watchdogReg <= pwdata[7:0];
			end
			if (paddr == ADDR_ALARM_MON) begin
				alarmMonthReg <= pwdata[7:0];
			end
		end
	end

	// Battery test at power-up and on a daily schedule
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			batteryCount    <= '0;
			batteryWeakFlag <= 1'b0;
		end else if (powerUp) begin
			batteryCount    <= '0;
			batteryWeakFlag <= batteryBelowLimit;
		end else if (powerState != RSV_BACKUP && supplyValid) begin
			if (batteryCount == BATTERY_W'(BATTERY_CHECK - 1)) begin
				batteryCount    <= '0;
				batteryWeakFlag <= batteryBelowLimit;
			end else begin
				batteryCount <= batteryCount + BATTERY_W'(1);
			end
		end
	end

	// Open-drain pin driven from the level bit only while its other uses are idle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			multiFunctionPinOut <= 1'b0;
			multiFunctionPinOe  <= 1'b0;
		end else begin
			multiFunctionPinOut <= 1'b0;
			// pulls low when level bit is zero
			multiFunctionPinOe  <= ~controlReg[BIT_FREQ_TEST]
				& ~alarmMonthReg[BIT_ALARM_FLAG_EN]
				& (watchdogReg == 8'h00)
				& ~controlReg[BIT_PIN_LEVEL]
				& supplyValid;
		end
	end

	// Oscillator runs while the halt bit is zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			oscillatorRun <= 1'b0;
		end else begin
			oscillatorRun <= ~secondsReg[BIT_OSC_HALT];
		end
	end
endmodule

// *** rsv_supervisor_chk.sv ***
// Port-level assertions for the supervisor
`timescale 1ns/10ps
module rsv_supervisor_chk #(
	parameter longint SLOW_REJECT = 20
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic resetInFast_n,
	input wire logic resetInSlow_n,
	input wire logic powerfailSenseBelow,
	input wire logic supplyValid,
	input wire logic systemReset_n,
	input wire logic powerfailFlagOut,
	input wire logic multiFunctionPinOut,
	input wire logic multiFunctionPinOe
);
	localparam int RST_MAX = 70;
	// Saturated so long real-time reject counts still fit the 8-bit low counter
	localparam logic [7:0] SLOW_MIN = (SLOW_REJECT > 257) ? 8'hff : 8'(SLOW_REJECT - 2);
	logic [7:0] fastLow;
	logic [7:0] slowLow;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Low-time counters tell which input could have started a reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fastLow <= 8'h00;
			slowLow <= 8'h00;
		end else begin
			fastLow <= resetInFast_n ? 8'h00 : fastLow + 8'(fastLow != 8'hff);
			slowLow <= resetInSlow_n ? 8'h00 : slowLow + 8'(slowLow != 8'hff);
		end
	end
	sequence s_held;
		!systemReset_n [*8];
	endsequence
	sequence s_up;
		s_held ##[1:RST_MAX] systemReset_n;
	endsequence
	a_backup_low: assert property (!supplyValid |=> !powerfailFlagOut && !systemReset_n)
		else $error("outputs not low in backup");
	a_recover_forced: assert property ($rose(supplyValid) |=> (powerfailFlagOut && !systemReset_n) [*8])
		else $error("recovery outputs wrong");
	a_follow_sense: assert property (systemReset_n && $past(systemReset_n) && supplyValid
		&& $past(supplyValid) |-> powerfailFlagOut == !$past(powerfailSenseBelow))
		else $error("flag does not follow sense");
	a_reset_cause: assert property ($fell(systemReset_n) && $past(supplyValid)
		|-> $past(fastLow) >= 8'h06 || $past(slowLow) >= SLOW_MIN)
		else $error("reset from short low");
	a_release_window: assert property (($rose(resetInFast_n) || $rose(resetInSlow_n))
		&& resetInFast_n && resetInSlow_n && !systemReset_n && supplyValid |=> s_up)
		else $error("release delay wrong");
	a_ready_answer: assert property (psel && penable && !$past(penable) |=> pready)
		else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready too long");
	a_error_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_pin_drive: assert property (multiFunctionPinOe |-> !multiFunctionPinOut && $past(supplyValid))
		else $error("pin driven wrongly");
endmodule
bind rsv_supervisor rsv_supervisor_chk #(.SLOW_REJECT(SLOW_REJECT)) u_chk (.clk, .reset, .psel,
	.penable, .pready, .pslverr, .resetInFast_n, .resetInSlow_n, .powerfailSenseBelow,
	.supplyValid, .systemReset_n, .powerfailFlagOut, .multiFunctionPinOut, .multiFunctionPinOe);

// *** tb_rsv_supervisor.sv ***
// Self-checking bench for the supervisor with a register model
`timescale 1ns/10ps
module tb_rsv_supervisor;
	import rsv_pkg::*;
	localparam int HN = 50;
	localparam int HH = 30;
	localparam int HS = 10;
	localparam int RL = 40;
	localparam int BC = 300;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        resetInFast_n = 1'b1;
	logic        resetInSlow_n = 1'b1;
	logic        powerfailSenseBelow = 1'b0;
	logic        supplyValid = 1'b0;
	logic        batteryRetained = 1'b0;
	logic        batteryBelowLimit = 1'b1;
	logic        centuryRollover = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, systemReset_n, powerfailFlagOut, pinLevel;
	logic        multiFunctionPinOut, multiFunctionPinOe, oscillatorRun, pinHi;
	int          resetEntries;
	int          errors = 0;
	int          compares = 0;
	int          cyc = 0;
	int          seed = 16161;
	logic [7:0]  flg;
	logic [7:0]  mdl [logic [7:0]];
	logic [7:0]  cen [3] = '{8'h80, 8'hc0, 8'h40};
	logic [7:0]  pa [7] = '{ADDR_CONTROL, ADDR_WATCHDOG, ADDR_WATCHDOG, ADDR_ALARM_MON,
		ADDR_ALARM_MON, ADDR_CONTROL, ADDR_CONTROL};
	logic [7:0]  pd [7] = '{8'h00, 8'h1e, 8'h00, 8'h80, 8'h00, 8'h40, 8'h80};
	int          rk [6] = '{1, 1, 0, 0, 1, 1};
	int          rw [6] = '{5, 12, 15, 26, 12, 12};
	int          rn [6] = '{1, 1, 1, 1, 2, 1};
	int          ra [6] = '{0, 1, 0, 1, 1, 1};
	rsv_supervisor #(.SLOW_REJECT(20), .HOLD_NORMAL(HN), .HOLD_HALTED(HH), .HOLD_SHORT(HS),
		.RELEASE_LONG(RL), .BATTERY_CHECK(BC)) dut (.clk, .reset, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .resetInFast_n, .resetInSlow_n,
		.powerfailSenseBelow, .supplyValid, .batteryRetained, .batteryBelowLimit,
		.centuryRollover, .systemReset_n, .powerfailFlagOut, .multiFunctionPinOut,
		.multiFunctionPinOe, .oscillatorRun);
	rsv_host_model host (.systemReset_n, .pinOe(multiFunctionPinOe),
		.pinOut(multiFunctionPinOut), .pinLevel, .resetEntries);
	initial forever #4 clk = ~clk;
	task automatic wrap_up();
		if (errors == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc > 9000) begin
			errors++;
			wrap_up();
		end
	end
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic xfer(logic wr, logic [7:0] a, logic [7:0] d, logic [7:0] e, logic ee);
		logic [31:0] rd;
		logic er;
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// Only the bench timeout ends a wait for the slave
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (!wr) chk("prdata", rd, {24'h0, e});
		chk("pslverr", er, ee);
	endtask
	task automatic wrm(logic [7:0] a, logic [7:0] d);
		mdl[a] = d;
		xfer(1'b1, a, d, 8'h00, 1'b0);
	endtask
	task automatic untilUp();
		int n;
		n = 0;
		while (systemReset_n !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic powerUp(int hold);
		int t0;
		t0 = cyc;
		flg = batteryBelowLimit ? 8'h10 : 8'h00;
		supplyValid <= 1'b1;
		@(posedge clk);
		xfer(1'b1, ADDR_CONTROL, 8'h55, 8'h00, 1'b1);
		untilUp();
		chk("hold", cyc - t0 >= hold && cyc - t0 <= hold + 6, 1'b1);
		chk("pfo", powerfailFlagOut, 1'b1);
		xfer(1'b0, ADDR_FLAGS, 8'h00, flg, 1'b0);
		xfer(1'b1, ADDR_FLAGS, 8'hff, 8'h00, 1'b1);
	endtask
	task automatic powerDown();
		supplyValid <= 1'b0;
		repeat (BC + 20) @(posedge clk);
		chk("pfo", powerfailFlagOut, 1'b0);
		chk("rst", systemReset_n, 1'b0);
		xfer(1'b0, ADDR_FLAGS, 8'h00, flg, 1'b0);
		mdl[ADDR_WATCHDOG] = 8'h00;
		mdl[ADDR_ALARM_MON] = 8'h00;
		mdl[ADDR_CONTROL][6] = 1'b0;
	endtask
	task automatic pulse(logic fast, int width, int times, int rel);
		int t0;
		int e0;
		e0 = resetEntries;
		repeat (times) begin
			if (fast) resetInFast_n <= 1'b0;
			else resetInSlow_n <= 1'b0;
			repeat (width) @(posedge clk);
			resetInFast_n <= 1'b1;
			resetInSlow_n <= 1'b1;
			t0 = cyc;
			repeat (3) @(posedge clk);
		end
		untilUp();
		chk("entries", resetEntries - e0, rel > 0);
		if (rel > 0) chk("release", cyc - t0 >= rel && cyc - t0 <= rel + 6, 1'b1);
	endtask
	initial begin
		mdl = '{ADDR_SECONDS: 8'h00, ADDR_CENTURY: RESET_CENTURY, ADDR_DESELECT: 8'h00,
			ADDR_CONTROL: 8'h80, ADDR_WATCHDOG: 8'h00, ADDR_ALARM_MON: 8'h00};
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
		chk("oscRun", oscillatorRun, 1'b1);
		foreach (mdl[a]) xfer(1'b0, a, 8'h00, mdl[a], 1'b0);
		xfer(1'b0, 8'h08, 8'h00, 8'h00, 1'b1);
		xfer(1'b1, ADDR_CONTROL, 8'h00, 8'h00, 1'b1);
		powerUp(HN);
		batteryBelowLimit <= 1'b0;
		xfer(1'b0, ADDR_FLAGS, 8'h00, flg, 1'b0);
		repeat (BC) @(posedge clk);
		flg = 8'h00;
		xfer(1'b0, ADDR_FLAGS, 8'h00, flg, 1'b0);
		repeat (16) begin
			powerfailSenseBelow <= 1'($random(seed));
			repeat (2) @(posedge clk);
			chk("pfo", powerfailFlagOut, !powerfailSenseBelow);
		end
		powerfailSenseBelow <= 1'b0;
		foreach (cen[i]) begin
			wrm(ADDR_CENTURY, cen[i]);
			centuryRollover <= 1'b1;
			@(posedge clk);
			centuryRollover <= 1'b0;
			if (cen[i][7]) mdl[ADDR_CENTURY] ^= 8'h40;
			xfer(1'b0, ADDR_CENTURY, 8'h00, mdl[ADDR_CENTURY], 1'b0);
		end
		foreach (pa[i]) begin
			wrm(pa[i], pd[i]);
			@(posedge clk);
			pinHi = mdl[ADDR_CONTROL][7:6] != 2'h0 || mdl[ADDR_WATCHDOG] != 8'h00;
			chk("pin", pinLevel, pinHi || mdl[ADDR_ALARM_MON][7]);
		end
		foreach (rk[i]) begin
			if (i == 5) wrm(ADDR_DESELECT, 8'h80);
			pulse(rk[i][0], rw[i], rn[i], ra[i] ? (i == 5 ? HS : RL) : 0);
		end
		wrm(ADDR_DESELECT, 8'h00);
		wrm(ADDR_SECONDS, 8'h80);
		wrm(ADDR_WATCHDOG, 8'h1e);
		wrm(ADDR_ALARM_MON, 8'he0);
		wrm(ADDR_CONTROL, 8'h40);
		@(posedge clk);
		chk("oscRun", oscillatorRun, 1'b0);
		batteryRetained <= 1'b1;
		batteryBelowLimit <= 1'b1;
		powerDown();
		powerUp(HH);
		foreach (mdl[a]) xfer(1'b0, a, 8'h00, mdl[a], 1'b0);
		chk("pin", pinLevel, 1'b0);
		wrm(ADDR_DESELECT, 8'h80);
		powerDown();
		powerUp(HS);
		wrap_up();
	end
endmodule
